// file: ssfl_pkg.sv
// Shared constants, register map and types of the supply sequencer fault logic.
package ssfl_pkg;

    localparam int CLK_MHZ = 200;
    // Precision comparator sampling period, and the cycles it spans.
    localparam int SAMPLE_TIME_NS = 20000;
    localparam int SAMPLE_CYCLES = SAMPLE_TIME_NS * CLK_MHZ / 1000;
    // Cycles the fault line is left released before its level is trusted.
    localparam logic [2:0] LINE_SETTLE_CYCLES = 3'h5;

    localparam int ADDR_W = 4;
    localparam logic [3:0] OFFS_CTRL = 4'h0;
    localparam logic [3:0] OFFS_DELAY = 4'h4;
    localparam logic [3:0] OFFS_STATUS = 4'h8;
    localparam logic [3:0] OFFS_CAUSE = 4'hc;

    localparam int CTRL_PGT_USE_BIT = 0;
    localparam int CTRL_SIMUL_OFF_BIT = 1;
    localparam logic [15:0] DELAY_RESET = 16'h0010;

    localparam int CAUSE_SEQ_BIT = 0;
    localparam int CAUSE_FAST_BIT = 1;
    localparam int CAUSE_DROP_BIT = 2;
    localparam int CAUSE_RISE_BIT = 3;
    localparam int CAUSE_PGT_BIT = 4;
    localparam int CAUSE_EXT_BIT = 5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        SEQ_IDLE = 5'h01,
        SEQ_PWR_ON = 5'h02,
        SEQ_ON_DONE = 5'h04,
        SEQ_PWR_OFF = 5'h08,
        SEQ_FAULT = 5'h10
    } ssfl_seq_t;

    // Raw comparator levels arriving from the analog front end.
    typedef struct packed {
        logic fault_line;
        logic pgt_over;
        logic seq_cmd;
        logic [3:0] fast_low;
        logic [3:0] supply_sense;
    } ssfl_cmp_t;

    localparam int CMP_W = $bits(ssfl_cmp_t);
    // A released fault line idles high, so its synchroniser must not wake up showing a pull.
    localparam logic [CMP_W-1:0] CMP_RESET = 11'h400;

    typedef struct packed {
        ssfl_seq_t seq;
        logic [1:0] idx;
        logic wait_sense;
        logic [15:0] dly;
        logic [3:0] en;
        logic [3:0] conf;
        logic done;
        logic fault;
        logic ext;
        logic pull;
        logic [2:0] settle;
        logic tmr_oe;
        logic tmr_o;
        logic pgt_run;
        logic pgt_use;
        logic simul_off;
        logic [15:0] delay;
        logic [5:0] cause;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ssfl_state_t;

endpackage

// file: ssfl_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module ssfl_sync #(
    parameter int WIDTH = 1,
    // Level shown during reset, chosen to match the idle level of each pin.
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// file: ssfl_sampler.sv
// Periodic sampler that turns precision comparator levels into decisions.
`timescale 1ns/1ps
module ssfl_sampler #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] sample_out
);

    logic [11:0] cnt_q;
    logic [WIDTH-1:0] smp_q;

    // Decisions only move once per period, trading latency for accuracy.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= '0;
            smp_q <= '0;
        end
        else if (cnt_q == 12'(ssfl_pkg::SAMPLE_CYCLES - 1))
        begin
            cnt_q <= '0;
            smp_q <= level_in;
        end
        else
        begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    assign sample_out = smp_q;

endmodule

// file: ssfl_top.sv
// Supply sequencer fault detection, latching, reporting and clearing logic.
// Contract
// - Clear fault only with all senses low.
// - Clear fault only with command low.
// - External fault holds while line pulled.
// - External origin drives timer pin low.
// - Internal origin drives timer pin high.
// - Origin indication frozen until command low.
// - Track supplies on; monitor after done.
// - Sense low when on: fault, all off.
// - Precision decision sampled every twenty microseconds.
// - Fast low detector faults within one microsecond.
// - Command drop during power-on is fault.
// - Command rise during power-off is fault.
// - Power-good timeout during power-on is fault.
// - Line pulled externally: external fault, enables off.
// - Keep pulling line until clear conditions.
// - Internal fault pulls line immediately.
// - Power-good timer runs from enable to sense.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ssfl_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ssfl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssfl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ssfl_pkg::ssfl_cmp_t cmp_in,
    output logic [3:0] supply_enable,
    output logic seq_done,
    output logic fault_line_o,
    output logic fault_line_oe,
    output logic delay_timer_pin_o,
    output logic delay_timer_pin_oe,
    output logic power_good_timer_run
);

    ssfl_pkg::ssfl_state_t q;
    ssfl_pkg::ssfl_state_t d;
    ssfl_pkg::ssfl_cmp_t cmp_s;
    logic [4:0] smp;
    logic [3:0] s_sense;
    logic s_cmd;
    logic ev_seq;
    logic ev_fast;
    logic ev_drop;
    logic ev_rise;
    logic ev_pgt;
    logic ev_int;
    logic ev_ext;
    logic clr_ok;
    logic [5:0] cause_set;
    logic [5:0] cause_clr;
    logic [31:0] rd_val;
    logic rd_hit;
    logic wr_hit;

    ssfl_sync #(
        .WIDTH(ssfl_pkg::CMP_W),
        .RESET_VAL(ssfl_pkg::CMP_RESET)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(cmp_in),
        .sync_out(cmp_s)
    );

    ssfl_sampler #(
        .WIDTH(5)
    ) u_sampler (
        .aclk(aclk),
        .aresetn(aresetn),
        .level_in({cmp_s.seq_cmd, cmp_s.supply_sense}),
        .sample_out(smp)
    );

    assign s_sense = smp[3:0];
    assign s_cmd = smp[4];

    always_comb
    begin
        // Sampled sense low on a confirmed supply.
        ev_seq = |(q.conf & ~s_sense);
        // Fast low path bypasses the sampler.
        ev_fast = |(q.conf & cmp_s.fast_low);
        ev_drop = (q.seq == ssfl_pkg::SEQ_PWR_ON) && !s_cmd;
        ev_rise = (q.seq == ssfl_pkg::SEQ_PWR_OFF) && s_cmd;
        ev_pgt = (q.seq == ssfl_pkg::SEQ_PWR_ON) && q.pgt_use && cmp_s.pgt_over;
        ev_int = ev_seq || ev_fast || ev_drop || ev_rise || ev_pgt;
        // Our own pull reads back low, so external sensing waits for the release.
        ev_ext = !cmp_s.fault_line && !q.pull && (q.seq != ssfl_pkg::SEQ_FAULT);
        clr_ok = (s_sense == 4'h0) && !s_cmd;
    end

    always_comb
    begin
        cause_set = 6'h00;
        if (q.seq != ssfl_pkg::SEQ_FAULT)
        begin
            cause_set[ssfl_pkg::CAUSE_SEQ_BIT] = ev_seq;
            cause_set[ssfl_pkg::CAUSE_FAST_BIT] = ev_fast;
            cause_set[ssfl_pkg::CAUSE_DROP_BIT] = ev_drop;
            cause_set[ssfl_pkg::CAUSE_RISE_BIT] = ev_rise;
            cause_set[ssfl_pkg::CAUSE_PGT_BIT] = ev_pgt;
            cause_set[ssfl_pkg::CAUSE_EXT_BIT] = ev_ext && !ev_int;
        end
    end

    always_comb
    begin
        rd_hit = 1'b1;
        unique case (q.aw_addr)
            ssfl_pkg::OFFS_CTRL, ssfl_pkg::OFFS_DELAY, ssfl_pkg::OFFS_CAUSE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        unique case (s_axi_araddr)
            ssfl_pkg::OFFS_CTRL: rd_val = {30'h0000_0000, q.simul_off, q.pgt_use};
            ssfl_pkg::OFFS_DELAY: rd_val = {16'h0000, q.delay};
            ssfl_pkg::OFFS_STATUS: rd_val = {10'h000, q.seq, s_cmd, s_sense, q.pull, q.ext,
                                             q.fault, q.done, q.conf, q.en};
            ssfl_pkg::OFFS_CAUSE: rd_val = {26'h000_0000, q.cause};
            default:
            begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        d = q;
        cause_clr = 6'h00;

        // Register bus: address and data are taken in either order.
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_held = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_held = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        if (q.aw_held && q.w_held && !q.bvalid)
        begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wr_hit ? ssfl_pkg::RESP_OKAY : ssfl_pkg::RESP_SLVERR;
            if (q.aw_addr == ssfl_pkg::OFFS_CTRL && q.w_strb[0])
            begin
                d.pgt_use = q.w_data[ssfl_pkg::CTRL_PGT_USE_BIT];
                d.simul_off = q.w_data[ssfl_pkg::CTRL_SIMUL_OFF_BIT];
            end
            if (q.aw_addr == ssfl_pkg::OFFS_DELAY)
            begin
                if (q.w_strb[0])
                begin
                    d.delay[7:0] = q.w_data[7:0];
                end
                if (q.w_strb[1])
                begin
                    d.delay[15:8] = q.w_data[15:8];
                end
            end
            if (q.aw_addr == ssfl_pkg::OFFS_CAUSE && q.w_strb[0])
            begin
                cause_clr = q.w_data[5:0];
            end
        end
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = rd_val;
            d.rresp = rd_hit ? ssfl_pkg::RESP_OKAY : ssfl_pkg::RESP_SLVERR;
        end
        // A cause raised in the cycle of its clear survives.
        d.cause = (q.cause & ~cause_clr) | cause_set;

        unique case (q.seq)
            ssfl_pkg::SEQ_IDLE:
            begin
                if (s_cmd && s_sense == 4'h0)
                begin
                    d.seq = ssfl_pkg::SEQ_PWR_ON;
                    d.idx = 2'h0;
                    d.wait_sense = 1'b0;
                    d.dly = q.delay;
                    d.done = 1'b0;
                end
            end
            ssfl_pkg::SEQ_PWR_ON:
            begin
                if (!q.wait_sense)
                begin
                    if (q.dly != 16'h0000)
                    begin
                        d.dly = q.dly - 16'h0001;
                    end
                    else
                    begin
                        d.en[q.idx] = 1'b1;
                        d.wait_sense = 1'b1;
                        d.pgt_run = 1'b1;
                    end
                end
                else if (s_sense[q.idx])
                begin
                    d.conf[q.idx] = 1'b1;
                    d.pgt_run = 1'b0;
                    d.wait_sense = 1'b0;
                    d.dly = q.delay;
                    if (q.idx == 2'h3)
                    begin
                        d.seq = ssfl_pkg::SEQ_ON_DONE;
                        d.done = 1'b1;
                    end
                    else
                    begin
                        d.idx = q.idx + 2'h1;
                    end
                end
            end
            ssfl_pkg::SEQ_ON_DONE:
            begin
                if (!s_cmd)
                begin
                    d.seq = ssfl_pkg::SEQ_PWR_OFF;
                    d.idx = 2'h3;
                    d.wait_sense = 1'b0;
                    d.dly = q.delay;
                    d.done = 1'b0;
                end
            end
            ssfl_pkg::SEQ_PWR_OFF:
            begin
                if (q.simul_off)
                begin
                    if (!q.wait_sense)
                    begin
                        d.en = 4'h0;
                        d.conf = 4'h0;
                        d.wait_sense = 1'b1;
                    end
                    else if (s_sense == 4'h0)
                    begin
                        d.seq = ssfl_pkg::SEQ_IDLE;
                        d.done = 1'b1;
                    end
                end
                else if (!q.wait_sense)
                begin
                    if (q.dly != 16'h0000)
                    begin
                        d.dly = q.dly - 16'h0001;
                    end
                    else
                    begin
                        d.en[q.idx] = 1'b0;
                        d.conf[q.idx] = 1'b0;
                        d.wait_sense = 1'b1;
                    end
                end
                else if (!s_sense[q.idx])
                begin
                    d.wait_sense = 1'b0;
                    d.dly = q.delay;
                    if (q.idx == 2'h0)
                    begin
                        d.seq = ssfl_pkg::SEQ_IDLE;
                        d.done = 1'b1;
                    end
                    else
                    begin
                        d.idx = q.idx - 2'h1;
                    end
                end
            end
            ssfl_pkg::SEQ_FAULT:
            begin
                // Origin is not touched again while latched.
                if (q.pull)
                begin
                    // Pull held until senses and command low.
                    if (clr_ok)
                    begin
                        d.pull = 1'b0;
                        d.settle = 3'h0;
                    end
                end
                else if (!clr_ok)
                begin
                    d.pull = 1'b1;
                end
                else if (q.settle != ssfl_pkg::LINE_SETTLE_CYCLES)
                begin
                    d.settle = q.settle + 3'h1;
                end
                // External fault waits for a released line.
                else if (!q.ext || cmp_s.fault_line)
                begin
                    d.seq = ssfl_pkg::SEQ_IDLE;
                    d.fault = 1'b0;
                    d.ext = 1'b0;
                    d.tmr_oe = 1'b0;
                end
            end
            default:
            begin
                d.seq = ssfl_pkg::SEQ_FAULT;
            end
        endcase

        if ((ev_int || ev_ext) && q.seq != ssfl_pkg::SEQ_FAULT)
        begin
            d.seq = ssfl_pkg::SEQ_FAULT;
            d.en = 4'h0;
            d.conf = 4'h0;
            d.fault = 1'b1;
            d.done = 1'b0;
            d.pgt_run = 1'b0;
            d.wait_sense = 1'b0;
            d.settle = 3'h0;
            d.pull = 1'b1;
            d.ext = !ev_int;
            d.tmr_oe = 1'b1;
            // Low for external, high for internal.
            d.tmr_o = ev_int;
        end

        d.awready = !d.aw_held;
        d.wready = !d.w_held;
        d.arready = !d.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.seq <= ssfl_pkg::SEQ_IDLE;
            q.delay <= ssfl_pkg::DELAY_RESET;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    assign supply_enable = q.en;
    assign seq_done = q.done;
    // The line is open drain: only ever driven low.
    assign fault_line_o = 1'b0;
    assign fault_line_oe = q.pull;
    assign delay_timer_pin_o = q.tmr_o;
    assign delay_timer_pin_oe = q.tmr_oe;
    assign power_good_timer_run = q.pgt_run;

endmodule

// file: ssfl_top_properties.sv
// Concurrent checks on the ports of the supply sequencer fault logic.
`timescale 1ns/1ps
module ssfl_top_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ssfl_pkg::ssfl_cmp_t cmp_in,
    input wire logic [3:0] supply_enable,
    input wire logic seq_done,
    input wire logic fault_line_oe,
    input wire logic delay_timer_pin_o,
    input wire logic delay_timer_pin_oe,
    input wire logic power_good_timer_run
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic ext_low;
    // Our own pull also reads back low, so only a low line we leave alone is someone else.
    assign ext_low = !cmp_in.fault_line && !fault_line_oe;

    en_off_fault_a: assert property (delay_timer_pin_oe |-> supply_enable == 4'h0)
        else $error("enables high while a fault is latched");
    pull_on_fault_a: assert property ($rose(delay_timer_pin_oe) |-> fault_line_oe)
        else $error("fault latched without pulling the line");
    origin_hold_a: assert property (
        delay_timer_pin_oe && $past(delay_timer_pin_oe) |-> $stable(delay_timer_pin_o))
        else $error("origin indication changed during a fault");
    fast_low_a: assert property (
        seq_done && supply_enable == 4'hf && $rose(cmp_in.fast_low != 4'h0)
        |-> ##[1:3] (supply_enable == 4'h0 && fault_line_oe))
        else $error("fast low detector too slow");
    ext_origin_a: assert property (
        $fell(cmp_in.fault_line) && !fault_line_oe && !delay_timer_pin_oe
        |-> ##[1:3] (delay_timer_pin_oe && !delay_timer_pin_o))
        else $error("outside pull not taken as external fault");
    int_origin_a: assert property (
        $rose(delay_timer_pin_oe) && $past(cmp_in.fault_line) |-> delay_timer_pin_o)
        else $error("own fault not shown as internal");
    clear_cond_a: assert property (
        $fell(delay_timer_pin_oe) |-> cmp_in.supply_sense == 4'h0 && !cmp_in.seq_cmd)
        else $error("fault cleared with sense or command high");
    ext_hold_a: assert property (
        delay_timer_pin_oe && !delay_timer_pin_o && ext_low && $past(ext_low)
        && $past(ext_low, 2) |=> delay_timer_pin_oe)
        else $error("external fault cleared while line held low");
    pgt_start_a: assert property (
        (supply_enable & ~$past(supply_enable)) != 4'h0 |-> ##[0:1] power_good_timer_run)
        else $error("power good timer not started by enable");

    cover property ($rose(seq_done));
    cover property ($rose(delay_timer_pin_oe) && !delay_timer_pin_o);
    cover property ($fell(delay_timer_pin_oe));
endmodule

bind ssfl_top ssfl_top_properties chk_u (.aclk, .aresetn, .cmp_in, .supply_enable, .seq_done,
    .fault_line_oe, .delay_timer_pin_o, .delay_timer_pin_oe, .power_good_timer_run);

// file: ssfl_partner.sv
// Behavioural supplies, wired fault line and power good capacitor around the fault logic.
`timescale 1ns/1ps
module ssfl_partner (
    input wire logic aclk,
    input wire logic [3:0] supply_enable,
    input wire logic fault_line_o,
    input wire logic fault_line_oe,
    input wire logic power_good_timer_run,
    input wire logic cmd,
    input wire logic ext_pull,
    input wire logic [3:0] fail,
    input wire logic [3:0] stuck,
    output ssfl_pkg::ssfl_cmp_t cmp_in
);
    logic [3:0] ramp_q [8];
    logic [9:0] pgt_q;
    logic [3:0] sense;
    // Supplies ramp eight cycles behind their enables; a failed one never comes up.
    always_ff @(posedge aclk)
    begin
        ramp_q[0] <= supply_enable;
        for (int i = 1; i < 8; i++)
        begin
            ramp_q[i] <= ramp_q[i - 1];
        end
        pgt_q <= power_good_timer_run ? pgt_q + 10'h001 : 10'h000;
    end
    assign sense = (ramp_q[7] & ~fail) | stuck;
    always_comb
    begin
        cmp_in.supply_sense = sense;
        cmp_in.fast_low = ~sense;
        cmp_in.seq_cmd = cmd;
        cmp_in.pgt_over = pgt_q >= 10'h0c8;
        // A released line floats up through its pull-up resistor.
        cmp_in.fault_line = !((fault_line_oe && !fault_line_o) || ext_pull);
    end
endmodule

// file: ssfl_top_tb.sv
// Directed regression of the supply sequencer fault logic over AXI4-Lite and its pins.
`timescale 1ns/1ps
module ssfl_top_tb;
    localparam int LIMIT = 100000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    ssfl_pkg::ssfl_cmp_t cmp_in;
    logic [3:0] supply_enable;
    logic seq_done, fault_line_o, fault_line_oe;
    logic delay_timer_pin_o, delay_timer_pin_oe, power_good_timer_run;
    logic cmd = 1'b0, ext_pull = 1'b0;
    logic [3:0] fail = 4'h0, stuck = 4'h0;
    int n_errors = 0, checked = 0, cycles = 0;

    always #2.5 aclk = ~aclk;

    ssfl_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_in, .supply_enable,
        .seq_done, .fault_line_o, .fault_line_oe, .delay_timer_pin_o, .delay_timer_pin_oe,
        .power_good_timer_run);
    ssfl_partner far_u (.aclk, .supply_enable, .fault_line_o, .fault_line_oe,
        .power_good_timer_run, .cmd, .ext_pull, .fail, .stuck, .cmp_in);

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        chk(what, 32'(exp), 32'(got));
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk_resp("bresp", er, s_axi_bresp);
    endtask

    // Reads a register and compares the masked word and the response.
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_resp("rresp", er, s_axi_rresp);
        chk("rdata", e, s_axi_rdata & m);
    endtask

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset_pins", 32'h0000_0001, 32'({supply_enable, fault_line_oe, s_axi_awready}));
        rd(4'h0, 32'hffff_ffff, 32'h0000_0000, 2'h0);
        rd(4'h4, 32'hffff_ffff, 32'h0000_0010, 2'h0);
        rd(4'h8, 32'hffff_ffff, 32'h0002_0000, 2'h0);
        rd(4'hc, 32'hffff_ffff, 32'h0000_0000, 2'h0);
        rd(4'h2, 32'h0000_0000, 32'h0000_0000, 2'h2);
        wr(4'h8, 32'h0000_0000, 2'h2);
        wr(4'h6, 32'h0000_0000, 2'h2);
        wr(4'h4, 32'h0000_0008, 2'h0);
        rd(4'h4, 32'hffff_ffff, 32'h0000_0008, 2'h0);
        cmd <= 1'b1;
        repeat (100) @(posedge aclk);
        chk("on_wait", 32'h0000_0000, 32'(supply_enable));
        while (seq_done !== 1'b1) @(posedge aclk);
        chk("on_enables", 32'h0000_000f, 32'(supply_enable));
        rd(4'h8, 32'hffff_ffff, 32'h0009_f1ff, 2'h0);
        fail <= 4'h4;
        repeat (4) @(posedge aclk);
        chk("fast_fault", 32'h0000_000e, 32'({supply_enable, fault_line_oe,
            delay_timer_pin_oe, delay_timer_pin_o, seq_done}));
        rd(4'hc, 32'h0000_0002, 32'h0000_0002, 2'h0);
        wr(4'hc, 32'h0000_003f, 2'h0);
        rd(4'hc, 32'hffff_ffff, 32'h0000_0000, 2'h0);
        // The wait outlasts one sampling period so a wrong clear would show.
        repeat (4100) @(posedge aclk);
        chk("hold_cmd", 32'h0000_0003, 32'({delay_timer_pin_oe, delay_timer_pin_o}));
        stuck <= 4'h1;
        cmd <= 1'b0;
        repeat (4100) @(posedge aclk);
        chk("hold_sense", 32'h0000_0001, 32'(delay_timer_pin_oe));
        stuck <= 4'h0;
        fail <= 4'h0;
        while (delay_timer_pin_oe !== 1'b0) @(posedge aclk);
        rd(4'h8, 32'hffff_ffff, 32'h0002_0000, 2'h0);
        ext_pull <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("ext_fault", 32'h0000_0002, 32'({supply_enable, delay_timer_pin_oe,
            delay_timer_pin_o}));
        rd(4'hc, 32'h0000_0020, 32'h0000_0020, 2'h0);
        repeat (200) @(posedge aclk);
        chk("ext_hold", 32'h0000_0001, 32'(delay_timer_pin_oe));
        ext_pull <= 1'b0;
        while (delay_timer_pin_oe !== 1'b0) @(posedge aclk);
        chk("ext_release", 32'h0000_0000, 32'({fault_line_o, fault_line_oe}));
        wr(4'hc, 32'h0000_003f, 2'h0);
        cmd <= 1'b1;
        while (supply_enable[0] !== 1'b1) @(posedge aclk);
        cmd <= 1'b0;
        while (delay_timer_pin_oe !== 1'b1) @(posedge aclk);
        chk("drop_fault", 32'h0000_0003, 32'({supply_enable, fault_line_oe,
            delay_timer_pin_o}));
        rd(4'hc, 32'h0000_0004, 32'h0000_0004, 2'h0);
        while (delay_timer_pin_oe !== 1'b0) @(posedge aclk);
        wr(4'hc, 32'h0000_003f, 2'h0);
        wr(4'h0, 32'h0000_0001, 2'h0);
        fail <= 4'h1;
        cmd <= 1'b1;
        while (delay_timer_pin_oe !== 1'b1) @(posedge aclk);
        chk("pgt_fault", 32'h0000_0003, 32'({supply_enable, fault_line_oe,
            delay_timer_pin_o}));
        rd(4'hc, 32'h0000_0010, 32'h0000_0010, 2'h0);
        cmd <= 1'b0;
        fail <= 4'h0;
        while (delay_timer_pin_oe !== 1'b0) @(posedge aclk);
        wr(4'h0, 32'h0000_0000, 2'h0);
        wr(4'hc, 32'h0000_003f, 2'h0);
        cmd <= 1'b1;
        while (seq_done !== 1'b1) @(posedge aclk);
        cmd <= 1'b0;
        while (supply_enable === 4'hf) @(posedge aclk);
        chk("off_order", 32'h0000_0007, 32'(supply_enable));
        cmd <= 1'b1;
        while (delay_timer_pin_oe !== 1'b1) @(posedge aclk);
        chk("rise_fault", 32'h0000_0003, 32'({supply_enable, fault_line_oe,
            delay_timer_pin_o}));
        rd(4'hc, 32'h0000_0008, 32'h0000_0008, 2'h0);
        cmd <= 1'b0;
        while (delay_timer_pin_oe !== 1'b0) @(posedge aclk);
        report_and_stop();
    end
endmodule
